// >>> rtl/dsr_top.sv
// top of the dma status and soft burst request block
//
// Chosen here: register access over AXI4-Lite.
module dsr_top
    import dsr_pkg::*;
#(
    parameter int CH = dsr_pkg::N_CH,
    parameter int RQ = dsr_pkg::REQ_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dsr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dsr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [dsr_pkg::N_CH-1:0] count_done_evt,
    input wire logic [dsr_pkg::N_CH-1:0] bus_fault_evt,
    input wire logic [dsr_pkg::N_CH-1:0] chan_start,
    input wire logic [dsr_pkg::N_CH-1:0] chan_finish,
    input wire logic [dsr_pkg::REQ_W-1:0] hw_burst_req,
    input wire logic [dsr_pkg::REQ_W-1:0] burst_done,
    output logic [dsr_pkg::REQ_W-1:0] burst_req,
    output logic [dsr_pkg::N_CH-1:0] channel_active_flag,
    output logic irq
);
    // ****************************************
    // bus front end
    // ****************************************
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic rd_ok;

    dsr_axil_slave u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_fire(wr_fire),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ****************************************
    // address match
    // ****************************************
    // full twelve-bit compare, so no register answers at an alias
    logic hit_wr_tc_clear;
    logic hit_wr_err_clear;
    logic hit_wr_raw_tc;
    logic hit_wr_raw_err;
    logic hit_wr_enabled;
    logic hit_wr_sw_burst;
    logic hit_wr_tc_en;
    logic hit_wr_err_en;

    logic hit_rd_tc_clear;
    logic hit_rd_err_clear;
    logic hit_rd_raw_tc;
    logic hit_rd_raw_err;
    logic hit_rd_enabled;
    logic hit_rd_sw_burst;
    logic hit_rd_tc_en;
    logic hit_rd_err_en;

    assign hit_wr_tc_clear = (wr_addr == OFF_TC_CLEAR);
    assign hit_wr_err_clear = (wr_addr == OFF_ERR_CLEAR);
    assign hit_wr_raw_tc = (wr_addr == OFF_RAW_TC);
    assign hit_wr_raw_err = (wr_addr == OFF_RAW_ERR);
    assign hit_wr_enabled = (wr_addr == OFF_ENABLED);
    assign hit_wr_sw_burst = (wr_addr == OFF_SW_BURST);
    assign hit_wr_tc_en = (wr_addr == OFF_TC_IRQ_EN);
    assign hit_wr_err_en = (wr_addr == OFF_ERR_IRQ_EN);

    assign hit_rd_tc_clear = (rd_addr == OFF_TC_CLEAR);
    assign hit_rd_err_clear = (rd_addr == OFF_ERR_CLEAR);
    assign hit_rd_raw_tc = (rd_addr == OFF_RAW_TC);
    assign hit_rd_raw_err = (rd_addr == OFF_RAW_ERR);
    assign hit_rd_enabled = (rd_addr == OFF_ENABLED);
    assign hit_rd_sw_burst = (rd_addr == OFF_SW_BURST);
    assign hit_rd_tc_en = (rd_addr == OFF_TC_IRQ_EN);
    assign hit_rd_err_en = (rd_addr == OFF_ERR_IRQ_EN);

    // ****************************************
    // write decode
    // ****************************************
    logic [DATA_W-1:0] byte_mask;
    logic [DATA_W-1:0] wr_bits;
    logic [CH-1:0] wr_bits_ch;
    logic [RQ-1:0] wr_bits_rq;
    logic wr_tc_clear;
    logic wr_err_clear;
    logic wr_sw_burst;
    logic wr_tc_en;
    logic wr_err_en;
    logic wr_read_only;

    // disabled byte lanes write as zero: no effect on the clear and burst registers, but the irq enables load those zeros
    assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_bits = wr_data & byte_mask;
    assign wr_bits_ch = wr_bits[CH-1:0];
    assign wr_bits_rq = wr_bits[RQ-1:0];
    assign wr_tc_clear = wr_fire & hit_wr_tc_clear;
    assign wr_err_clear = wr_fire & hit_wr_err_clear;
    assign wr_sw_burst = wr_fire & hit_wr_sw_burst;
    assign wr_tc_en = wr_fire & hit_wr_tc_en;
    assign wr_err_en = wr_fire & hit_wr_err_en;
    // writes to status registers are ignored but answered okay
    assign wr_read_only = hit_wr_raw_tc | hit_wr_raw_err | hit_wr_enabled;
    assign wr_ok = wr_read_only | hit_wr_tc_clear | hit_wr_err_clear | hit_wr_sw_burst
        | hit_wr_tc_en | hit_wr_err_en;

    // ****************************************
    // raw count-done and fault flags
    // ****************************************
    logic [CH-1:0] tc_clr;
    logic [CH-1:0] err_clr;
    logic [CH-1:0] raw_count_done_flag;
    logic [CH-1:0] raw_fault_flag;

    assign tc_clr = wr_tc_clear ? wr_bits_ch : CH_RESET;
    assign err_clr = wr_err_clear ? wr_bits_ch : CH_RESET;

    // set straight from the engine events, no enable in the path
    dsr_sticky_bank #(.W(CH)) u_tc_flags (
        .core_clk(core_clk),
        .rst(rst),
        .set_bits(count_done_evt),
        .clr_bits(tc_clr),
        .flags(raw_count_done_flag)
    );

    dsr_sticky_bank #(.W(CH)) u_err_flags (
        .core_clk(core_clk),
        .rst(rst),
        .set_bits(bus_fault_evt),
        .clr_bits(err_clr),
        .flags(raw_fault_flag)
    );

    // ****************************************
    // channel active flags
    // ****************************************
    // a restart in the finishing cycle keeps the channel active
    dsr_sticky_bank #(.W(CH)) u_active (
        .core_clk(core_clk),
        .rst(rst),
        .set_bits(chan_start),
        .clr_bits(chan_finish),
        .flags(channel_active_flag)
    );

    // ****************************************
    // software burst requests
    // ****************************************
    logic [RQ-1:0] sw_set;
    logic [RQ-1:0] sw_burst_request_bit;
    logic [RQ-1:0] all_req;
    logic [RQ-1:0] hw_req_in;
    logic [RQ-1:0] burst_req_ff;

    // reserved bits are masked, a stray one cannot raise a request
    assign sw_set = wr_sw_burst ? (wr_bits_rq & SW_BURST_MASK) : REQ_RESET;

    // a write in the completing cycle keeps its request, set wins
    dsr_sticky_bank #(.W(RQ)) u_sw_burst (
        .core_clk(core_clk),
        .rst(rst),
        .set_bits(sw_set),
        .clr_bits(burst_done),
        .flags(sw_burst_request_bit)
    );

    // hardware lines outside the mask are not ours to pass on
    assign hw_req_in = hw_burst_req & SW_BURST_MASK;
    // software and hardware requests merge by OR; both at once give the union of the two
    assign all_req = sw_burst_request_bit | hw_req_in;
    assign burst_req = burst_req_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            burst_req_ff <= REQ_RESET;
        end else begin
            burst_req_ff <= all_req;
        end
    end

    // ****************************************
    // interrupt enables and output
    // ****************************************
    logic [CH-1:0] tc_en_ff;
    logic [CH-1:0] err_en_ff;
    logic [CH-1:0] tc_masked;
    logic [CH-1:0] err_masked;
    logic irq_ff;
    logic nxt_irq;

    // masking only gates the pin, the raw flags stay readable
    assign tc_masked = raw_count_done_flag & tc_en_ff;
    assign err_masked = raw_fault_flag & err_en_ff;
    assign nxt_irq = (|tc_masked) | (|err_masked);
    assign irq = irq_ff;

    // one flop between flags and pin, so the pin never glitches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tc_en_ff <= CH_RESET;
            err_en_ff <= CH_RESET;
            irq_ff <= 1'b0;
        end else begin
            if (wr_tc_en) begin
                tc_en_ff <= wr_bits_ch;
            end
            if (wr_err_en) begin
                err_en_ff <= wr_bits_ch;
            end
            irq_ff <= nxt_irq;
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    logic [DATA_W-1:0] rd_tc;
    logic [DATA_W-1:0] rd_err;
    logic [DATA_W-1:0] rd_act;
    logic [DATA_W-1:0] rd_sw;
    logic [DATA_W-1:0] rd_tce;
    logic [DATA_W-1:0] rd_erre;
    logic rd_clear_reg;

    // unused upper bits read as zero
    assign rd_tc = {{(DATA_W-CH){1'b0}}, raw_count_done_flag};
    assign rd_err = {{(DATA_W-CH){1'b0}}, raw_fault_flag};
    assign rd_act = {{(DATA_W-CH){1'b0}}, channel_active_flag};
    assign rd_sw = {{(DATA_W-RQ){1'b0}}, all_req};
    assign rd_tce = {{(DATA_W-CH){1'b0}}, tc_en_ff};
    assign rd_erre = {{(DATA_W-CH){1'b0}}, err_en_ff};

    // write-only clear registers answer okay and read as zero
    assign rd_clear_reg = hit_rd_tc_clear | hit_rd_err_clear;
    assign rd_data = hit_rd_raw_tc ? rd_tc
        : hit_rd_raw_err ? rd_err
        : hit_rd_enabled ? rd_act
        : hit_rd_sw_burst ? rd_sw
        : hit_rd_tc_en ? rd_tce
        : hit_rd_err_en ? rd_erre
        : '0;
    assign rd_ok = rd_clear_reg | hit_rd_raw_tc | hit_rd_raw_err | hit_rd_enabled
        | hit_rd_sw_burst | hit_rd_tc_en | hit_rd_err_en;
endmodule : dsr_top

// >>> rtl/dsr_pkg.sv
// constants and register map of the dma status and soft request block
package dsr_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int N_CH = 8;
    localparam int REQ_W = 15;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_TC_CLEAR = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_ERR_CLEAR = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_RAW_TC = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_RAW_ERR = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_ENABLED = 12'h01c;
    localparam logic [ADDR_W-1:0] OFF_SW_BURST = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_TC_IRQ_EN = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_ERR_IRQ_EN = 12'h044;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam logic [REQ_W-1:0] SW_BURST_MASK = 15'h4c1f;
    localparam int BIT_UART_TX = 0;
    localparam int BIT_UART_RX = 1;
    localparam int BIT_SSP_TX = 2;
    localparam int BIT_SSP_RX = 3;
    localparam int BIT_NAND = 4;
    localparam int BIT_AUDIO_ONE = 10;
    localparam int BIT_AUDIO_ZERO = 11;
    localparam int BIT_LCD_ACCEL = 14;
    localparam logic [N_CH-1:0] CH_RESET = 8'h00;
    localparam logic [REQ_W-1:0] REQ_RESET = 15'h0000;

    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dsr_pkg

// >>> rtl/dsr_sticky_bank.sv
// bank of sticky flags where a set wins over a clear in the same cycle
module dsr_sticky_bank #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] set_bits,
    input wire logic [W-1:0] clr_bits,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;

    // set beats clear so no event is lost
    assign nxt_flags = set_bits | (flags_ff & ~clr_bits);
    assign flags = flags_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule : dsr_sticky_bank

// >>> rtl/dsr_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
module dsr_axil_slave
    import dsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dsr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dsr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_fire,
    output logic [dsr_pkg::ADDR_W-1:0] wr_addr,
    output logic [dsr_pkg::DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [dsr_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [dsr_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_ok
);
    logic aw_held_ff, w_held_ff, bvalid_ff, awready_ff, wready_ff;
    logic ar_pend_ff, rvalid_ff, arready_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [ADDR_W-1:0] awaddr_ff, araddr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_take, w_take, ar_take;
    logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid, nxt_ar_pend;

    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take = s_axi_wvalid & wready_ff;
    assign ar_take = s_axi_arvalid & arready_ff;
    assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign nxt_aw_held = ~wr_fire & (aw_held_ff | aw_take);
    assign nxt_w_held = ~wr_fire & (w_held_ff | w_take);
    assign nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
    assign nxt_ar_pend = ar_take;
    assign nxt_rvalid = ar_pend_ff | (rvalid_ff & ~s_axi_rready);
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;
    assign wr_strb = wstrb_ff;
    assign rd_addr = araddr_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            bvalid_ff <= nxt_bvalid;
            // no new write taken until the response has gone
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            if (aw_take) awaddr_ff <= s_axi_awaddr;
            if (w_take) wdata_ff <= s_axi_wdata;
            if (w_take) wstrb_ff <= s_axi_wstrb;
            if (wr_fire) bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ar_pend_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            araddr_ff <= '0;
            rdata_ff <= '0;
        end else begin
            ar_pend_ff <= nxt_ar_pend;
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_ar_pend & ~nxt_rvalid;
            if (ar_take) araddr_ff <= s_axi_araddr;
            if (ar_pend_ff) rdata_ff <= rd_data;
            if (ar_pend_ff) rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end
endmodule : dsr_axil_slave

// >>> verification/dsr_far_model.sv
// far side model: channel engines, peripheral request lines, burst engine
module dsr_far_model #(
    parameter int LAT = 20,
    parameter int BLAT = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] go,
    input wire logic [7:0] fault,
    input wire logic [14:0] hw_go,
    input wire logic stall,
    input wire logic [14:0] burst_req,
    output logic [7:0] chan_start,
    output logic [7:0] chan_finish,
    output logic [7:0] count_done_evt,
    output logic [7:0] bus_fault_evt,
    output logic [14:0] hw_burst_req,
    output logic [14:0] burst_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_ff, bad_ff;
    int cnt_ff, bcnt_ff;
    // ****************************************
    // one shared run timer, one burst timer
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {run_ff, bad_ff, chan_start, chan_finish, count_done_evt, bus_fault_evt} <= '0;
            {hw_burst_req, burst_done} <= '0;
            cnt_ff <= 0;
            bcnt_ff <= 0;
        end else begin
            chan_start <= go;
            chan_finish <= (cnt_ff == 1) ? run_ff : '0;
            count_done_evt <= (cnt_ff == 1) ? run_ff & ~bad_ff : '0;
            bus_fault_evt <= (cnt_ff == 1) ? run_ff & bad_ff : '0;
            if (go != '0) begin
                cnt_ff <= LAT;
                run_ff <= go;
                bad_ff <= fault;
            end else if (cnt_ff > 0) begin
                cnt_ff <= cnt_ff - 1;
            end
            burst_done <= '0;
            // peripheral holds its line until its burst is served
            hw_burst_req <= hw_burst_req | hw_go;
            if (burst_req == '0 || stall) begin
                bcnt_ff <= 0;
            end else if (bcnt_ff == BLAT) begin
                burst_done <= burst_req;
                hw_burst_req <= (hw_burst_req | hw_go) & ~burst_req;
                bcnt_ff <= 0;
            end else begin
                bcnt_ff <= bcnt_ff + 1;
            end
        end
    end
endmodule : dsr_far_model

// >>> verification/dsr_top_assertions.sv
// port level assertions of the dma status and soft burst request block
module dsr_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [dsr_pkg::N_CH-1:0] chan_start,
    input wire logic [dsr_pkg::N_CH-1:0] chan_finish,
    input wire logic [dsr_pkg::N_CH-1:0] channel_active_flag,
    input wire logic [dsr_pkg::REQ_W-1:0] hw_burst_req,
    input wire logic [dsr_pkg::REQ_W-1:0] burst_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import dsr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_late; !s_axi_rvalid ##1 s_axi_rvalid; endsequence
    burst_mask_a: assert property ((burst_req & ~SW_BURST_MASK) == '0)
        else $error("burst request outside the line mask");
    hw_pass_a: assert property ((burst_req & $past(hw_burst_req) & SW_BURST_MASK) ==
        ($past(hw_burst_req) & SW_BURST_MASK)) else $error("hardware request not passed on");
    start_sets_a: assert property ((channel_active_flag & $past(chan_start)) == $past(chan_start))
        else $error("active flag missing after start");
    finish_clears_a: assert property ((channel_active_flag & $past(chan_finish) & ~$past(chan_start)) == '0)
        else $error("active flag kept after finish");
    active_hold_a: assert property ((channel_active_flag & ~$past(channel_active_flag) & ~$past(chan_start)) == '0)
        else $error("active flag rose without start");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address accepted while busy");
    ar_block_a: assert property (ar_take |=> !s_axi_arready [*2])
        else $error("read address accepted while busy");
    rd_lat_a: assert property (ar_take |=> r_late)
        else $error("read answer not two cycles after address");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule : dsr_checker
bind dsr_top dsr_checker i_dsr_checker (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .chan_start, .chan_finish,
    .channel_active_flag, .hw_burst_req, .burst_req);

// >>> verification/dsr_top_bench.sv
// self-checking testbench of the dma status and soft burst request block
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dsr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] count_done_evt, bus_fault_evt, chan_start, chan_finish, channel_active_flag;
    logic [7:0] go = '0, fault = '0;
    logic [14:0] hw_burst_req, burst_done, burst_req, hw_go = '0;
    logic stall = 1'b0;
    int n_errors = 0, n_compared = 0;
    dsr_top i_dsr_top (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .count_done_evt, .bus_fault_evt, .chan_start, .chan_finish, .hw_burst_req,
        .burst_done, .burst_req, .channel_active_flag, .irq);
    dsr_far_model #(.LAT(20), .BLAT(4)) i_dsr_far_model (.core_clk, .rst, .go, .fault, .hw_go,
        .stall, .burst_req, .chan_start, .chan_finish, .count_done_evt, .bus_fault_evt,
        .hw_burst_req, .burst_done);
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        if (n >= 40) begin
            n_errors++;
            end_sim();
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, dsr_pkg::RESP_OKAY)
        `CHK(s_axi_rdata, e)
        if (n >= 40) begin
            n_errors++;
            end_sim();
        end
    endtask : rd
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_reset();
        rd(12'h014, 32'h0);
        rd(12'h018, 32'h0);
        rd(12'h01c, 32'h0);
        rd(12'h020, 32'h0);
        wr(12'h0fc, 32'h1, dsr_pkg::RESP_SLVERR);
    endtask : s_reset
    task automatic s_channels();
        go <= 8'h05;
        fault <= 8'h04;
        @(posedge core_clk);
        go <= '0;
        fault <= '0;
        rd(12'h01c, 32'h05);
        repeat (30) @(posedge core_clk);
        rd(12'h01c, 32'h0);
        rd(12'h014, 32'h01);
        rd(12'h018, 32'h04);
        `CHK(irq, 1'b0)
        wr(12'h014, 32'hff, dsr_pkg::RESP_OKAY);
        rd(12'h014, 32'h01);
    endtask : s_channels
    task automatic s_irq();
        wr(12'h040, 32'h01, dsr_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(12'h008, 32'h00, dsr_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(12'h008, 32'h01, dsr_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        rd(12'h014, 32'h0);
        wr(12'h044, 32'h04, dsr_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(12'h010, 32'h04, dsr_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
    endtask : s_irq
    task automatic s_soft();
        stall <= 1'b1;
        wr(12'h020, 32'h4c1f, dsr_pkg::RESP_OKAY);
        rd(12'h020, 32'h4c1f);
        `CHK(burst_req, 15'h4c1f)
        wr(12'h020, 32'h0, dsr_pkg::RESP_OKAY);
        rd(12'h020, 32'h4c1f);
        stall <= 1'b0;
        repeat (12) @(posedge core_clk);
        rd(12'h020, 32'h0);
        `CHK(burst_req, 15'h0)
    endtask : s_soft
    task automatic s_hw();
        stall <= 1'b1;
        hw_go <= 15'h0002;
        @(posedge core_clk);
        hw_go <= '0;
        repeat (3) @(posedge core_clk);
        rd(12'h020, 32'h0002);
        stall <= 1'b0;
        repeat (12) @(posedge core_clk);
        rd(12'h020, 32'h0);
    endtask : s_hw
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        s_reset();
        s_channels();
        s_irq();
        s_soft();
        s_hw();
        end_sim();
    end
endmodule : dsr_top_bench
